// File: redundancy_manager.v
// The register addresses and the address-and-strobe port are this design's own decisions.
`include "redundancy_manager_defs.vh"

// Operation
// RULE1: Status bits 0..2 flag lockstep mismatch of pairs 1-2, 1-3, 2-3.
// RULE2: Status bits 4..6 flag fatal error of pairs 1-2, 1-3, 2-3.
// RULE3: Bit 7 fatal voter error, bit 8 fatal ECC, bit 9 watchdog expired.
// RULE4: Bits 11:10 hold phase: nominal, lockstep, recovery reset, fatal.
// RULE5: Bits 12..14 name the faulty processor while mismatch field nonzero.
// RULE6: Status vector drives all zeros after reset.
// RULE7: Lockstep break output is low after reset.
// RULE8: Recovery reset output is low after reset.
// RULE9: Fatal output is low after reset.
// RULE10: Processors drive the recover request input during lockstep break.
// RULE11: Up to 64 comparator mismatch inputs are accepted.
// RULE12: An uncorrectable error input from the memory bus is accepted.
// RULE13: Drive peer link vector, zero initially; accept links from three peers.
// RULE14: With mitigation port enabled, controller supplies its status inputs.
// RULE15: Pulse lost output rises when mitigation heartbeat stops.
// RULE16: Mitigation event interrupt output, low after reset.
// RULE17: Comparator test vector drives capture, clear and inject, zero initially.
// RULE18: Synchronous active high reset clears all state.
// RULE19: Status bits 31..15 are driven as zero.
// RULE20: Status bit 3 shows recovery in progress or occurred.
module redundancy_manager #(
   parameter NCMP = 64,
   parameter LINK_W = 8,
   parameter TEST_W = 4,
   parameter mitig_port_cfg = 1,
   parameter TEST_COMPARATOR = 1
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Fault tolerance
   input wire redundancy_off,
   input wire debug_off,
   input wire recover_req,
   output reg lockstep_break,
   output reg recovery_rst,
   output reg fatal,
   output reg [31:0] status,
   input wire [NCMP-1:0] cmp_mismatch,
   input wire membus_hard_err,
   input wire voter_err,
   output wire wdog_expired,
   input wire wdog_pause,
   // Peer links
   output reg [LINK_W-1:0] peer_link_out,
   input wire [LINK_W-1:0] peer_link_in_a,
   input wire [LINK_W-1:0] peer_link_in_b,
   input wire [LINK_W-1:0] peer_link_in_c,
   // Mitigation controller
   input wire mitig_pulse,
   input wire mitig_init_st,
   input wire mitig_observe_st,
   input wire mitig_correct_st,
   input wire mitig_classify_st,
   input wire mitig_inject_st,
   input wire mitig_critical_st,
   input wire mitig_hard_st,
   input wire mitig_scan_st,
   input wire mitig_observe_only_st,
   output wire mitig_pulse_lost,
   output reg mitig_event_irq,
   // Comparator test
   output reg [TEST_W-1:0] cmp_test,
   // Register port
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata
);
   localparam ST_NOM = 4'h1;
   localparam ST_LOCK = 4'h2;
   localparam ST_REC = 4'h4;
   localparam ST_FAT = 4'h8;
   // Recovery reset length in cycles, cut to the counter width on purpose
   localparam integer REC_CYC_I = `RECOVER_RST_CYC;
   localparam [7:0] REC_CYC = REC_CYC_I[7:0];

   // Input synchronisers
   reg [NCMP-1:0] cmp_s1_q, cmp_s2_q;
   reg [15:0] pin_s1_q, pin_s2_q;
   reg [3*LINK_W-1:0] peer_s1_q, peer_s2_q;
   always @(posedge clk) begin
      if (rst) begin
         cmp_s1_q <= {NCMP{1'b0}};
         cmp_s2_q <= {NCMP{1'b0}};
         pin_s1_q <= 16'h0000;
         pin_s2_q <= 16'h0000;
         peer_s1_q <= {(3*LINK_W){1'b0}};
         peer_s2_q <= {(3*LINK_W){1'b0}};
      end else begin
         cmp_s1_q <= cmp_mismatch; // RULE11
         cmp_s2_q <= cmp_s1_q;
         pin_s1_q <= {mitig_observe_only_st, mitig_scan_st, mitig_hard_st, mitig_critical_st,
                      mitig_inject_st, mitig_classify_st, mitig_correct_st, mitig_init_st,
                      mitig_observe_st, mitig_pulse, voter_err, wdog_pause,
                      membus_hard_err, recover_req, debug_off, redundancy_off}; // RULE12 RULE14
         pin_s2_q <= pin_s1_q;
         peer_s1_q <= {peer_link_in_c, peer_link_in_b, peer_link_in_a}; // RULE13
         peer_s2_q <= peer_s1_q;
      end
   end
   wire off_s = pin_s2_q[0];
   wire dbg_off_s = pin_s2_q[1];
   wire recover_s = pin_s2_q[2];
   wire ue_s = pin_s2_q[3];
   wire pause_s = pin_s2_q[4];
   wire voter_s = pin_s2_q[5];
   wire pulse_s = pin_s2_q[6];
   // All nine mitigation status levels, observation through detect-only
   wire [8:0] mitig_s = pin_s2_q[15:7];

   // Software registers
   reg [31:0] ctrl_q, wdog_reload_q, pulse_reload_q;
   reg [NCMP-1:0] mask_q;
   reg wdog_kick_q;
   always @(posedge clk) begin
      if (rst) begin
         ctrl_q <= `CTRL_RST_VAL;
         mask_q <= {NCMP{1'b0}};
         wdog_reload_q <= `WDOG_RST_VAL;
         pulse_reload_q <= `PULSE_TO_RST_VAL;
         wdog_kick_q <= 1'b0;
      end else begin
         ctrl_q[`CTRL_CLEAR] <= 1'b0;
         wdog_kick_q <= reg_wr && reg_addr == `REG_WDOG;
         if (reg_wr) begin
            case (reg_addr)
               `REG_CTRL: ctrl_q <= reg_wdata;
               `REG_MASK_LO: mask_q[31:0] <= reg_wdata;
               `REG_MASK_HI: mask_q[NCMP-1:32] <= reg_wdata[NCMP-33:0];
               `REG_WDOG: wdog_reload_q <= reg_wdata;
               `REG_PULSE_TO: pulse_reload_q <= reg_wdata;
               default: ;
            endcase
         end
      end
   end
   wire clear_fail = ctrl_q[`CTRL_CLEAR];

   // Pair mismatch detection: comparators interleaved across three pairs, bit b to pair b mod 3
   wire [NCMP-1:0] cmp_act = cmp_s2_q & ~mask_q;
   wire [2:0] pair_err;
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : pair_g
         wire [NCMP-1:0] sel;
         genvar b;
         for (b = 0; b < NCMP; b = b + 1) begin : bit_g
            assign sel[b] = cmp_act[b] && (b % 3 == g);
         end
         assign pair_err[g] = |sel;
      end
   endgenerate
   wire [1:0] npair = {1'b0, pair_err[0]} + {1'b0, pair_err[1]} + {1'b0, pair_err[2]};

   // Watchdog instances
   wire wdog_exp;
   pulse_watchdog #(.W(32)) u_wdog (
      .clk(clk),
      .rst(rst),
      .enable(wdog_reload_q != 32'h00000000 && !pause_s),
      .kick(wdog_kick_q),
      .reload(wdog_reload_q),
      .expired(wdog_exp)
   );
   assign wdog_expired = wdog_exp;
   reg pulse_d1_q;
   wire pulse_lost_w;
   pulse_watchdog #(.W(32)) u_pulse (
      .clk(clk),
      .rst(rst),
      .enable(mitig_port_cfg == 1),
      .kick(pulse_s != pulse_d1_q),
      .reload(pulse_reload_q),
      .expired(pulse_lost_w)
   );
   assign mitig_pulse_lost = (mitig_port_cfg == 1) ? pulse_lost_w : 1'b0; // RULE15

   // Tolerance phase machine
   reg [3:0] state_q;
   reg [7:0] rcnt_q;
   reg [2:0] ls_q, fat_q, proc_q;
   reg fvot_q, fecc_q, fwd_q, recd_q;
   reg [1:0] phase;
   always @* begin
      case (state_q)
         ST_NOM: phase = `PH_NOMINAL;
         ST_LOCK: phase = `PH_LOCKSTEP;
         ST_REC: phase = `PH_RECOVER;
         ST_FAT: phase = `PH_FATAL;
         default: phase = `PH_NOMINAL;
      endcase
   end
   always @(posedge clk) begin
      if (rst) begin // RULE18
         state_q <= ST_NOM;
         rcnt_q <= 8'h00;
         ls_q <= 3'h0;
         fat_q <= 3'h0;
         proc_q <= 3'h0;
         fvot_q <= 1'b0;
         fecc_q <= 1'b0;
         fwd_q <= 1'b0;
         recd_q <= 1'b0;
         pulse_d1_q <= 1'b0;
      end else begin
         pulse_d1_q <= pulse_s;
         fwd_q <= fwd_q | wdog_exp; // RULE3
         case (state_q)
            ST_NOM: begin
               if (!off_s && npair == 2'h1) begin
                  state_q <= ST_LOCK;
                  ls_q <= pair_err; // RULE1
                  // One-hot faulty processor follows the single mismatching pair
                  proc_q <= pair_err; // RULE5
               end else if (!off_s && npair > 2'h1) begin
                  state_q <= ST_FAT;
                  fat_q <= pair_err; // RULE2
               end else if (voter_s || ue_s) begin
                  state_q <= ST_FAT;
                  fvot_q <= voter_s;
                  fecc_q <= ue_s;
               end
            end
            ST_LOCK: begin
               if (recover_s) begin // RULE10
                  state_q <= ST_REC;
                  rcnt_q <= REC_CYC;
                  recd_q <= 1'b1; // RULE20
               end else if (ue_s || voter_s || (!off_s && npair > 2'h1)) begin
                  state_q <= ST_FAT;
                  fecc_q <= ue_s;
                  fvot_q <= voter_s;
                  fat_q <= (npair > 2'h1) ? pair_err : 3'h0;
               end
            end
            ST_REC: begin
               if (rcnt_q == 8'h01) begin
                  state_q <= ST_NOM;
                  ls_q <= 3'h0;
                  proc_q <= 3'h0;
               end
               rcnt_q <= rcnt_q - 8'h01;
            end
            ST_FAT: begin
               if (clear_fail) begin
                  state_q <= ST_NOM;
                  fat_q <= 3'h0;
                  ls_q <= 3'h0;
                  proc_q <= 3'h0;
                  fvot_q <= 1'b0;
                  fecc_q <= 1'b0;
               end
            end
            default: state_q <= ST_NOM;
         endcase
         if (clear_fail && !wdog_exp)
            fwd_q <= 1'b0;
      end
   end

   // Outputs
   reg [8:0] mitig_prev_q;
   // Next values shared by the outputs and the peer link, so both change together
   wire break_d = (state_q == ST_LOCK) && !ctrl_q[`CTRL_NO_BREAK] && !dbg_off_s; // RULE7
   wire fatal_d = (state_q == ST_FAT); // RULE9
   always @(posedge clk) begin
      if (rst) begin
         lockstep_break <= 1'b0; // RULE7
         recovery_rst <= 1'b0; // RULE8
         fatal <= 1'b0; // RULE9
         status <= `ST_RESET_VAL; // RULE6
         peer_link_out <= {LINK_W{1'b0}}; // RULE13
         mitig_event_irq <= 1'b0; // RULE16
         mitig_prev_q <= 9'h000;
         cmp_test <= {TEST_W{1'b0}}; // RULE17
         reg_rdata <= 32'h00000000;
      end else begin
         lockstep_break <= break_d;
         recovery_rst <= (state_q == ST_REC);
         fatal <= fatal_d;
         status <= {17'h00000, proc_q, phase, fwd_q, fecc_q, fvot_q, fat_q,
                    recd_q, ls_q}; // RULE1 RULE2 RULE4 RULE19
         peer_link_out <= {{(LINK_W-4){1'b0}}, phase, fatal_d, break_d}; // RULE13
         mitig_prev_q <= mitig_s;
         mitig_event_irq <= (mitig_port_cfg == 1) && (mitig_s != mitig_prev_q); // RULE16
         if (TEST_COMPARATOR > 0 && reg_wr && reg_addr == `REG_TEST)
            cmp_test <= reg_wdata[TEST_W-1:0]; // RULE17
         if (reg_rd) begin
            case (reg_addr)
               `REG_CTRL: reg_rdata <= ctrl_q;
               `REG_STATUS: reg_rdata <= status;
               `REG_MASK_LO: reg_rdata <= mask_q[31:0];
               `REG_MASK_HI: reg_rdata <= mask_q[NCMP-1:32];
               `REG_WDOG: reg_rdata <= wdog_reload_q;
               `REG_PULSE_TO: reg_rdata <= pulse_reload_q;
               `REG_TEST: reg_rdata <= {{(32-TEST_W){1'b0}}, cmp_test};
               default: reg_rdata <= 32'h00000000;
            endcase
         end else begin
            reg_rdata <= 32'h00000000;
         end
      end
   end
endmodule // redundancy_manager

// File: redundancy_manager_defs.vh
`ifndef REDUNDANCY_MANAGER_DEFS_VH
`define REDUNDANCY_MANAGER_DEFS_VH

// Status vector layout
`define ST_LS_12 0
`define ST_LS_13 1
`define ST_LS_23 2
`define ST_RECOVERY 3
`define ST_FATAL_12 4
`define ST_FATAL_13 5
`define ST_FATAL_23 6
`define ST_FATAL_VOTER 7
`define ST_FATAL_ECC 8
`define ST_WDOG 9
`define ST_PHASE_LO 10
`define ST_PHASE_HI 11
`define ST_PROC1 12
`define ST_PROC3 14
`define ST_RESET_VAL 32'h00000000

// Tolerance phase codes
`define PH_NOMINAL 2'h0
`define PH_LOCKSTEP 2'h1
`define PH_RECOVER 2'h2
`define PH_FATAL 2'h3

// Register port
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_MASK_LO 4'h2
`define REG_MASK_HI 4'h3
`define REG_WDOG 4'h4
`define REG_PULSE_TO 4'h5
`define REG_TEST 4'h6
`define CTRL_CLEAR 0
`define CTRL_NO_BREAK 1
`define CTRL_RST_VAL 32'h00000000

// Timing
`define RECOVER_RST_NS 400
`define CLK_NS 20
`define RECOVER_RST_CYC ((`RECOVER_RST_NS + `CLK_NS - 1) / `CLK_NS)
`define WDOG_RST_VAL 32'h00000000
`define PULSE_TO_RST_VAL 32'h00000400

`endif

// File: pulse_watchdog.v
`include "redundancy_manager_defs.vh"

// Counts down while enabled, restarts on a kick, flags expiry once reached zero
module pulse_watchdog #(
   parameter W = 32
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Control
   input wire enable,
   input wire kick,
   input wire [W-1:0] reload,
   // Result
   output reg expired
);
   reg [W-1:0] cnt_q;

   always @(posedge clk) begin
      if (rst) begin
         // Start from a full count so the flag stays low until a real timeout
         cnt_q <= reload;
         expired <= 1'b0;
      end else if (!enable || kick) begin
         cnt_q <= reload;
         expired <= 1'b0;
      end else if (cnt_q == {W{1'b0}}) begin
         expired <= 1'b1;
      end else begin
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule // pulse_watchdog

// File: redundancy_manager_props.sv
`include "redundancy_manager_defs.vh"

module redundancy_manager_props (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Watched ports
   input wire lockstep_break,
   input wire recovery_rst,
   input wire fatal,
   input wire [31:0] status,
   input wire mitig_event_irq,
   input wire [31:0] reg_rdata,
   input wire voter_err,
   input wire mitig_hard_st,
   input wire [3:0] reg_addr,
   input wire reg_rd
);
   reg [7:0] rcnt_q;
   wire [1:0] ph = status[11:10];
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // Length of the running recovery reset
   always @(posedge clk) begin
      if (rst || !recovery_rst)
         rcnt_q <= 8'h00;
      else
         rcnt_q <= rcnt_q + 8'h01;
   end

   reset_clear_a: assert property (disable iff (1'b0) rst |=> status == `ST_RESET_VAL
      && !fatal && !lockstep_break && !recovery_rst) else $error("outputs not cleared");
   break_phase_a: assert property (lockstep_break |-> ph == `PH_LOCKSTEP)
      else $error("break outside lockstep");
   fatal_phase_a: assert property (fatal == (ph == `PH_FATAL))
      else $error("fatal and phase differ");
   recov_phase_a: assert property (recovery_rst |-> ph == `PH_RECOVER)
      else $error("recovery outside phase");
   reserved_zero_a: assert property (status[31:15] == 17'h00000)
      else $error("reserved bits set");
   lockstep_pair_a: assert property (ph == `PH_LOCKSTEP |-> $onehot(status[2:0]))
      else $error("lockstep pair not single");
   fatal_cause_a: assert property (ph == `PH_FATAL |-> status[9:4] != 6'h00)
      else $error("fatal without cause");
   voter_fatal_a: assert property ($rose(voter_err) |-> ##[1:6] fatal)
      else $error("voter error not fatal");
   recov_len_a: assert property ($fell(recovery_rst) && !$past(rst) |-> rcnt_q == `RECOVER_RST_CYC)
      else $error("recovery length wrong");
   irq_event_a: assert property ($changed(mitig_hard_st) |-> ##[1:5] mitig_event_irq)
      else $error("no event irq");
   status_read_a: assert property (reg_rd && reg_addr == `REG_STATUS |=> reg_rdata == $past(status))
      else $error("status read wrong");

   cover property (lockstep_break);
   cover property ($fell(recovery_rst));
   cover property (fatal && status[8]);
   cover property (mitig_event_irq);
endmodule // redundancy_manager_props

bind redundancy_manager redundancy_manager_props u_props (.clk, .rst, .lockstep_break, .recovery_rst, .fatal,
   .status, .mitig_event_irq, .reg_rdata, .voter_err, .mitig_hard_st, .reg_addr, .reg_rd);

// File: proc_side_model.sv
module proc_side_model (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Scenario
   input wire [2:0] strike,
   input wire [4:0] grp,
   input wire slow,
   input wire pulse_on,
   // Manager side
   input wire lockstep_break,
   input wire recovery_rst,
   output reg [63:0] cmp_mismatch,
   output reg recover_req,
   output reg mitig_pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [4:0] wait_q;
   reg [3:0] beat_q;
   integer p;

   // Processors hold mismatches until the recovery reset
   always @(posedge clk) begin
      if (rst || recovery_rst) begin
         cmp_mismatch <= 64'h0;
         recover_req <= 1'b0;
         wait_q <= 5'h00;
      end else begin
         for (p = 0; p < 3; p = p + 1)
            if (strike[p]) cmp_mismatch[3 * grp + p] <= 1'b1;
         if (lockstep_break && wait_q != 5'h1F) wait_q <= wait_q + 5'h01;
         if (wait_q == (slow ? 5'h14 : 5'h01)) recover_req <= 1'b1;
      end
   end

   // Heartbeat toggles every 16 cycles while enabled
   always @(posedge clk) begin
      beat_q <= rst ? 4'h0 : beat_q + 4'h1;
      if (rst) mitig_pulse <= 1'b0;
      else if (pulse_on && beat_q == 4'hF) mitig_pulse <= !mitig_pulse;
   end
endmodule // proc_side_model

// File: redundancy_manager_tb_top.sv
`include "redundancy_manager_defs.vh"

module redundancy_manager_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg voter_err = 1'b0;
   reg membus_hard_err = 1'b0;
   reg slow = 1'b0;
   reg pulse_on = 1'b1;
   reg [2:0] strike = 3'h0;
   reg [4:0] grp = 5'h00;
   reg [8:0] mst = 9'h000;
   reg [23:0] peers = 24'h000000;
   reg [3:0] reg_addr = 4'h0;
   reg [31:0] reg_wdata = 32'h00000000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   wire lockstep_break, recovery_rst, fatal, recover_req, mitig_pulse, mitig_pulse_lost, mitig_event_irq, wdog_expired;
   wire [31:0] status, reg_rdata;
   wire [63:0] cmp_mismatch;
   wire [7:0] peer_link_out;
   wire [3:0] cmp_test;
   int n_fail = 0;
   int samples_checked = 0;

   always #10 clk = ~clk;

   redundancy_manager u_dut (.clk, .rst, .redundancy_off(1'b0), .debug_off(1'b0), .recover_req, .lockstep_break,
      .recovery_rst, .fatal, .status, .cmp_mismatch, .membus_hard_err, .voter_err, .wdog_expired, .wdog_pause(1'b0),
      .peer_link_out, .peer_link_in_a(peers[7:0]), .peer_link_in_b(peers[15:8]), .peer_link_in_c(peers[23:16]),
      .mitig_pulse, .mitig_init_st(mst[0]), .mitig_observe_st(mst[1]), .mitig_correct_st(mst[2]),
      .mitig_classify_st(mst[3]), .mitig_inject_st(mst[4]), .mitig_critical_st(mst[5]), .mitig_hard_st(mst[6]),
      .mitig_scan_st(mst[7]), .mitig_observe_only_st(mst[8]), .mitig_pulse_lost, .mitig_event_irq, .cmp_test,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   proc_side_model u_model (.clk, .rst, .strike, .grp, .slow, .pulse_on, .lockstep_break, .recovery_rst,
      .cmp_mismatch, .recover_req, .mitig_pulse);

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic reg_op(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= wr;
      reg_rd <= !wr;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge clk);
      q = reg_rdata;
   endtask

   task automatic wait_phase(input logic [1:0] ph);
      int i;
      for (i = 0; i < 200 && status[11:10] !== ph; i++) @(negedge clk);
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      #200000;
      n_fail++;
      final_report();
   end

   initial begin
      int p;
      int i;
      logic [2:0] m;
      logic [31:0] q;
      logic [31:0] v;
      v = $urandom(87953);
      do_reset();
      check(status, `ST_RESET_VAL, "status");
      check({mitig_pulse_lost, mitig_event_irq, lockstep_break, recovery_rst, fatal}, 32'h0, "flags");
      check({peer_link_out, cmp_test}, 32'h0, "links");
      $display("test reset done");
      for (p = 0; p < 3; p++) begin
         @(posedge clk);
         slow <= p[0];
         grp <= 5'($urandom_range(20));
         peers <= 24'($urandom);
         strike <= 3'(1 << p);
         @(posedge clk);
         strike <= 3'h0;
         wait_phase(`PH_LOCKSTEP);
         check({status[14:12], status[2:0]}, 32'(9 << p), "pair");
         check({status[11:10], peer_link_out}, 32'h105, "lockstep");
         wait_phase(`PH_RECOVER);
         check(recovery_rst, 32'h1, "recovery");
         wait_phase(`PH_NOMINAL);
         check({status[14:10], status[3:0], fatal}, 32'h10, "recovered");
         do_reset();
      end
      $display("test lockstep done");
      @(posedge clk);
      m = 3'h7 ^ 3'(1 << $urandom_range(3));
      strike <= m;
      @(posedge clk);
      strike <= 3'h0;
      wait_phase(`PH_FATAL);
      check({fatal, status[11:10], status[6:4]}, 32'({3'h7, m}), "fatal pairs");
      for (i = 0; i < 2; i++) begin
         do_reset();
         @(posedge clk);
         voter_err <= i[0];
         membus_hard_err <= !i[0];
         wait_phase(`PH_FATAL);
         check(status[8:7], i ? 32'h1 : 32'h2, "fatal cause");
         @(posedge clk);
         voter_err <= 1'b0;
         membus_hard_err <= 1'b0;
      end
      reg_op(1'b0, `REG_STATUS, 32'h0, q);
      check(q, 32'h00000C80, "status read");
      reg_op(1'b1, `REG_CTRL, 32'h00000001, q);
      wait_phase(`PH_NOMINAL);
      check(status, 32'h0, "failing cleared");
      do_reset();
      $display("test fatal done");
      reg_op(1'b1, `REG_PULSE_TO, 32'h00000040, q);
      repeat (20) @(posedge clk);
      pulse_on <= 1'b0;
      for (i = 0; i < 300 && mitig_pulse_lost !== 1'b1; i++) @(negedge clk);
      check(mitig_pulse_lost, 32'h1, "pulse lost");
      @(posedge clk);
      pulse_on <= 1'b1;
      mst <= mst ^ 9'($urandom_range(511, 1));
      for (i = 0; i < 8 && mitig_event_irq !== 1'b1; i++) @(negedge clk);
      check(mitig_event_irq, 32'h1, "event irq");
      $display("test mitigation done");
      v = $urandom_range(15);
      reg_op(1'b1, `REG_TEST, v, q);
      check(cmp_test, v, "test vector");
      reg_op(1'b0, `REG_TEST, 32'h0, q);
      check(q, v, "test readback");
      reg_op(1'b0, 4'($urandom_range(15, 7)), 32'h0, q);
      check(q, 32'h0, "unmapped read");
      reg_op(1'b1, `REG_WDOG, 32'h00000010, q);
      for (i = 0; i < 40 && wdog_expired !== 1'b1; i++) @(negedge clk);
      repeat (3) @(negedge clk);
      check({wdog_expired, status[9]}, 32'h3, "watchdog");
      $display("test registers done");
      final_report();
   end
endmodule // redundancy_manager_tb_top
